//--- core/atten_cmd_parser.sv
`timescale 1ns/1ps
module atten_cmd_parser #(
    parameter int CLOCK_HZ = atten_cmd_pkg::CLOCK_HZ,
    parameter int BAUD     = atten_cmd_pkg::BAUD_RATE
) (
    // Clock and reset
    input  wire logic                        i_ref_clk,
    input  wire logic                        i_reset_n,
    // Configuration
    input  wire logic                        i_multidrop,
    input  wire logic [4:0]                  i_unit_address,
    // Serial link
    input  wire logic                        i_rx,
    output logic                             o_tx,
    // Settings
    output logic [4*11-1:0]                  o_gain,
    output logic [4*7-1:0]                   o_offset,
    output logic                             o_update,
    output atten_cmd_pkg::setting_type       o_last_setting
);
    localparam int BITC = (CLOCK_HZ + BAUD / 2) / BAUD;
    localparam int BCW  = $clog2(BITC + 1);

    if (BAUD <= 0 || BITC < 4) begin : g_bad_baud
        $error("clock too slow for baud rate");
    end

    function automatic logic is_digit(input logic [7:0] c);
        return (c >= atten_cmd_pkg::CHAR_ZERO) && (c <= atten_cmd_pkg::CHAR_NINE);
    endfunction : is_digit

    function automatic logic [3:0] digit_val(input logic [7:0] c);
        return 4'(c - atten_cmd_pkg::CHAR_ZERO);
    endfunction : digit_val

    // ------------------------------------------------------------
    // Receiver, 8N1
    // ------------------------------------------------------------
    logic [BCW-1:0] rx_cnt;
    logic [3:0]     rx_bit;
    logic [7:0]     rx_shift;
    logic           rx_busy;
    logic           rx_valid;
    logic [7:0]     rx_byte;

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_cnt   <= '0;
            rx_bit   <= 4'h0;
            rx_shift <= 8'h00;
            rx_busy  <= 1'b0;
            rx_valid <= 1'b0;
            rx_byte  <= 8'h00;
        end else begin
            rx_valid <= 1'b0;
            if (!rx_busy) begin
                if (!i_rx) begin
                    rx_busy <= 1'b1;
                    rx_cnt  <= BCW'(BITC / 2);
                    rx_bit  <= 4'h0;
                end
            end else if (rx_cnt != '0) begin
                rx_cnt <= rx_cnt - 1'b1;
            end else begin
                rx_cnt <= BCW'(BITC - 1);
                rx_bit <= rx_bit + 4'h1;
                if (rx_bit == 4'h0) begin
                    if (i_rx) rx_busy <= 1'b0;  // Glitch, not a start bit
                end else if (rx_bit <= 4'(atten_cmd_pkg::DATA_BITS)) begin
                    rx_shift <= {i_rx, rx_shift[7:1]};
                end else begin
                    rx_busy <= 1'b0;
                    if (i_rx) begin  // Framing errors are dropped
                        rx_valid <= 1'b1;
                        rx_byte  <= rx_shift;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Parser
    // ------------------------------------------------------------
    typedef enum logic [7:0] {
        P_IDLE  = 8'h01,
        P_ADDR0 = 8'h02,
        P_ADDR1 = 8'h04,
        P_CMD   = 8'h08,
        P_CODE  = 8'h10,
        P_VALUE = 8'h20,
        P_ERROR = 8'h40,
        P_CHECK = 8'h80
    } parse_state_type;

    parse_state_type state;
    logic [6:0]  addr_acc;
    logic [1:0]  chan;
    logic        is_ofs;
    logic [13:0] mag;
    logic [2:0]  ndig;
    logic        seen_point;
    logic [1:0]  frac_dig;
    logic        seen_minus;
    logic        ack_req;

    wire logic [7:0] ch = rx_byte;
    // Full-width difference, so lower-case letters never alias onto gain codes
    wire logic [7:0] code_gain = ch - atten_cmd_pkg::CHAR_GAIN0;
    wire logic [7:0] code_ofs  = ch - atten_cmd_pkg::CHAR_OFS0;
    // Without a point the last digit is tenths; with a point, pad to tenths
    wire logic [13:0] tenths = (seen_point && frac_dig == 2'd0) ? 14'(mag * 10) : mag;
    wire logic [6:0]  cur_ofs = o_offset[chan*7 +: 7];
    wire logic [13:0] ofs_t   = 14'(cur_ofs * 10);

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state      <= P_IDLE;
            addr_acc   <= 7'h00;
            chan       <= 2'd0;
            is_ofs     <= 1'b0;
            mag        <= 14'h0000;
            ndig       <= 3'd0;
            seen_point <= 1'b0;
            frac_dig   <= 2'd0;
            seen_minus <= 1'b0;
        end else if (state == P_CHECK) begin
            state <= P_IDLE;
        end else if (rx_valid) begin
            if (ch == atten_cmd_pkg::CHAR_OPEN) begin
                state      <= i_multidrop ? P_ADDR0 : P_CMD;
                addr_acc   <= 7'h00;
                mag        <= 14'h0000;
                ndig       <= 3'd0;
                seen_point <= 1'b0;
                frac_dig   <= 2'd0;
                seen_minus <= 1'b0;
            end else begin
                case (state)
                    P_IDLE: state <= P_IDLE;
                    P_ADDR0, P_ADDR1: begin
                        if (is_digit(ch)) begin
                            addr_acc <= 7'(addr_acc * 10 + digit_val(ch));
                            state    <= (state == P_ADDR0) ? P_ADDR1 : P_CMD;
                        end else begin
                            state <= P_ERROR;
                        end
                    end
                    P_CMD: state <= (ch == atten_cmd_pkg::CHAR_CMD) ? P_CODE : P_ERROR;
                    P_CODE: begin
                        if (code_gain < 8'h04) begin
                            chan   <= code_gain[1:0];
                            is_ofs <= 1'b0;
                            state  <= P_VALUE;
                        end else if (code_ofs < 8'h04) begin
                            chan   <= code_ofs[1:0];
                            is_ofs <= 1'b1;
                            state  <= P_VALUE;
                        end else begin
                            state <= P_ERROR;
                        end
                    end
                    P_VALUE: begin
                        if (ch == atten_cmd_pkg::CHAR_CLOSE) begin
                            state <= P_CHECK;
                        end else if (ch == atten_cmd_pkg::CHAR_MINUS && ndig == 3'd0
                                     && !seen_minus && !is_ofs) begin
                            seen_minus <= 1'b1;
                        end else if (ch == atten_cmd_pkg::CHAR_POINT && !seen_point
                                     && !is_ofs && ndig != 3'd0) begin
                            seen_point <= 1'b1;
                        end else if (is_digit(ch) && ndig < 3'(atten_cmd_pkg::GAIN_DIGITS)
                                     && !(seen_point && frac_dig != 2'd0)) begin
                            mag  <= 14'(mag * 10 + digit_val(ch));
                            ndig <= ndig + 3'd1;
                            if (seen_point) frac_dig <= frac_dig + 2'd1;
                        end else begin
                            state <= P_ERROR;
                        end
                    end
                    P_ERROR: state <= P_ERROR;  // Wait for next opening brace
                    default: state <= P_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Validation and storage
    // ------------------------------------------------------------
    logic addr_ok, value_ok;
    always_comb begin
        addr_ok = !i_multidrop
                  || (addr_acc <= 7'(atten_cmd_pkg::ADDR_MAX)
                      && addr_acc[4:0] == i_unit_address);
        if (is_ofs) begin
            value_ok = (ndig == 3'd2) && (mag <= 14'(atten_cmd_pkg::OFS_MAX_DB));
        end else begin  // Range moves with the stored offset
            value_ok = (ndig >= 3'd2)
                       && (tenths >= ofs_t + 14'(atten_cmd_pkg::GAIN_MIN_REL))
                       && (tenths <= ofs_t + 14'(atten_cmd_pkg::GAIN_MAX_REL))
                       && (tenths % 14'(atten_cmd_pkg::GAIN_STEP) == 14'h0000);
        end
    end
    wire logic accept = (state == P_CHECK) && addr_ok && value_ok;

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < atten_cmd_pkg::NUM_CHANNELS; i++) begin
                o_gain[i*11 +: 11]  <= atten_cmd_pkg::GAIN_RESET;
                o_offset[i*7 +: 7]  <= atten_cmd_pkg::OFS_RESET;
            end
            o_update       <= 1'b0;
            o_last_setting <= '0;
            ack_req        <= 1'b0;
        end else begin
            o_update <= accept;
            ack_req  <= accept;
            if (accept) begin
                if (is_ofs) begin
                    o_offset[chan*7 +: 7] <= mag[6:0];
                end else begin
                    o_gain[chan*11 +: 11] <= tenths[10:0];  // Total, incl offset
                end
                o_last_setting.channel   <= chan;
                o_last_setting.is_offset <= is_ofs;
                o_last_setting.gain      <= is_ofs ? o_gain[chan*11 +: 11] : tenths[10:0];
                o_last_setting.offset    <= is_ofs ? mag[6:0] : cur_ofs;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmitter, sends only the acknowledge
    // ------------------------------------------------------------
    logic [BCW-1:0] tx_cnt;
    logic [3:0]     tx_bit;
    logic [9:0]     tx_shift;
    logic           tx_busy;

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tx_cnt   <= '0;
            tx_bit   <= 4'h0;
            tx_shift <= 10'h3FF;
            tx_busy  <= 1'b0;
            o_tx     <= 1'b1;
        end else if (!tx_busy) begin
            o_tx <= 1'b1;
            if (ack_req) begin
                tx_busy  <= 1'b1;
                tx_shift <= {1'b1, atten_cmd_pkg::CHAR_ACK, 1'b0};
                tx_bit   <= 4'h0;
                tx_cnt   <= '0;
            end
        end else if (tx_cnt != '0) begin
            tx_cnt <= tx_cnt - 1'b1;
        end else if (tx_bit == 4'd10) begin
            tx_busy <= 1'b0;
        end else begin
            o_tx     <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[9:1]};
            tx_bit   <= tx_bit + 4'h1;
            tx_cnt   <= BCW'(BITC - 1);
        end
    end

endmodule : atten_cmd_parser

//--- core/atten_cmd_pkg.sv
package atten_cmd_pkg;

    // ------------------------------------------------------------
    // Character codes
    // ------------------------------------------------------------
    localparam logic [7:0] CHAR_OPEN   = 8'h7B;
    localparam logic [7:0] CHAR_CLOSE  = 8'h7D;
    localparam logic [7:0] CHAR_CMD    = 8'h43;
    localparam logic [7:0] CHAR_GAIN0  = 8'h41;
    localparam logic [7:0] CHAR_OFS0   = 8'h61;
    localparam logic [7:0] CHAR_MINUS  = 8'h2D;
    localparam logic [7:0] CHAR_POINT  = 8'h2E;
    localparam logic [7:0] CHAR_ZERO   = 8'h30;
    localparam logic [7:0] CHAR_NINE   = 8'h39;
    localparam logic [7:0] CHAR_ACK    = 8'h3E;

    // ------------------------------------------------------------
    // Ranges, all in tenths of a dB except where noted
    // ------------------------------------------------------------
    localparam int         NUM_CHANNELS  = 4;
    localparam logic [4:0] ADDR_MAX      = 5'h1F;
    localparam logic [6:0] OFS_MAX_DB    = 7'h3C;
    localparam logic [9:0] GAIN_MIN_REL  = 10'h064;
    localparam logic [9:0] GAIN_MAX_REL  = 10'h2BC;
    localparam logic [9:0] GAIN_STEP     = 10'h005;
    localparam logic [10:0] GAIN_RESET   = 11'h064;
    localparam logic [6:0] OFS_RESET     = 7'h00;
    localparam int         GAIN_DIGITS   = 4;

    // ------------------------------------------------------------
    // Link
    // ------------------------------------------------------------
    localparam int BAUD_RATE = 9600;
    localparam int CLOCK_HZ  = 20000000;
    localparam int BIT_CYCLES = (CLOCK_HZ + BAUD_RATE / 2) / BAUD_RATE;
    localparam int DATA_BITS = 8;

    typedef struct packed {
        logic [1:0] channel;
        logic       is_offset;
        logic [10:0] gain;
        logic [6:0] offset;
    } setting_type;

endpackage : atten_cmd_pkg

//--- dv/atten_cmd_parser_asserts.sv
`timescale 1ns/1ps
module atten_cmd_parser_asserts #(
    parameter int CLOCK_HZ = atten_cmd_pkg::CLOCK_HZ,
    parameter int BAUD     = atten_cmd_pkg::BAUD_RATE
) (
    // Clock and reset
    input  wire logic                        i_ref_clk,
    input  wire logic                        i_reset_n,
    // Watched outputs
    input  wire logic                        o_tx,
    input  wire logic [4*11-1:0]             o_gain,
    input  wire logic [4*7-1:0]              o_offset,
    input  wire logic                        o_update,
    input  wire atten_cmd_pkg::setting_type  o_last_setting
);
    localparam int BITC = (CLOCK_HZ + BAUD / 2) / BAUD;
    logic [9:0] high_run;
    logic       quiet;
    logic       is_ofs;
    int         ofs10;
    // A high run of six bits or more cannot sit inside an ack frame
    assign quiet  = high_run >= 10'(6 * BITC);
    assign is_ofs = o_last_setting.is_offset;
    assign ofs10  = 10 * int'(o_offset[o_last_setting.channel*7 +: 7]);
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) high_run <= 10'h000;
        else if (!o_tx) high_run <= 10'h000;
        else if (high_run != 10'h3FF) high_run <= high_run + 10'h001;
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    a_update_single_pulse: assert property (o_update |=> !o_update)
        else $error("update pulse longer than one cycle");
    // Bit timing assumes the eight-cycle bit used on the bench
    a_ack_frame_start: assert property (BITC == 8 && o_update && quiet
        |=> ##1 (!o_tx)[*8] ##9 o_tx)
        else $error("ack start or first bits wrong");
    a_gain_only_on_update: assert property (!$stable(o_gain) |-> o_update)
        else $error("gain changed without accept");
    a_offset_only_update: assert property (!$stable(o_offset) |-> o_update)
        else $error("offset changed without accept");
    a_offset_stored: assert property (o_update && is_ofs |->
        o_offset[o_last_setting.channel*7 +: 7] == o_last_setting.offset)
        else $error("offset not stored in its channel");
    a_gain_stored: assert property (o_update && !is_ofs |->
        o_gain[o_last_setting.channel*11 +: 11] == o_last_setting.gain)
        else $error("gain not stored in its channel");
    a_gain_in_range: assert property (o_update && !is_ofs |->
        o_last_setting.gain % 5 == 0 && int'(o_last_setting.gain) >= ofs10 + 100
        && int'(o_last_setting.gain) <= ofs10 + 700)
        else $error("accepted gain outside range");
    a_offset_in_range: assert property (o_update && is_ofs |->
        o_last_setting.offset <= atten_cmd_pkg::OFS_MAX_DB)
        else $error("accepted offset above maximum");
endmodule : atten_cmd_parser_asserts

bind atten_cmd_parser atten_cmd_parser_asserts #(.CLOCK_HZ(CLOCK_HZ), .BAUD(BAUD))
    atten_cmd_parser_asserts_inst (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .o_tx(o_tx),
    .o_gain(o_gain), .o_offset(o_offset), .o_update(o_update), .o_last_setting(o_last_setting));

//--- dv/host_link_model.sv
`timescale 1ns/1ps
module host_link_model #(
    parameter int BITC = 8
) (
    input  wire logic i_ref_clk,
    input  wire logic i_line,
    output logic      o_line
);
    int ack_count = 0;
    int bad_count = 0;
    initial o_line = 1'b1;
    // One start, eight data bits LSB first, one stop, no parity
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge i_ref_clk);
            o_line = f[i];
            repeat (BITC - 1) @(negedge i_ref_clk);
        end
    endtask : send_byte
    // Only a clean ack frame counts; anything else is a bad frame
    always begin
        logic [7:0] r;
        @(negedge i_line);
        repeat (BITC / 2) @(posedge i_ref_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BITC) @(posedge i_ref_clk);
            r[i] = i_line;
        end
        repeat (BITC) @(posedge i_ref_clk);
        if (r === atten_cmd_pkg::CHAR_ACK && i_line === 1'b1) ack_count++;
        else bad_count++;
    end
endmodule : host_link_model

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int BAUD     = 9600;
    localparam int CLOCK_HZ = BAUD * 8;
    logic                       i_ref_clk = 1'b0;
    logic                       i_reset_n = 1'b0;
    logic                       i_multidrop = 1'b0;
    logic [4:0]                 i_unit_address = 5'h00;
    logic                       rx_line;
    logic                       tx_line;
    logic [43:0]                gain_bus;
    logic [27:0]                offset_bus;
    logic [10:0]                exp_gain [4];
    logic [6:0]                 exp_ofs [4];
    int                         exp_acks = 0;
    int                         fail_count = 0;
    int                         comparisons = 0;
    int                         cycles = 0;
    int                         v;
    int                         a;
    string                      pfx = "";
    atten_cmd_parser #(.CLOCK_HZ(CLOCK_HZ), .BAUD(BAUD)) atten_cmd_parser_inst (
        .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_multidrop(i_multidrop),
        .i_unit_address(i_unit_address), .i_rx(rx_line), .o_tx(tx_line), .o_gain(gain_bus),
        .o_offset(offset_bus), .o_update(), .o_last_setting());
    host_link_model #(.BITC(8)) host_link_model_inst (
        .i_ref_clk(i_ref_clk), .i_line(tx_line), .o_line(rx_line));
    always #25 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 80000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    task automatic chk_vec(input string n, input logic [43:0] e, input logic [43:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk_vec
    task automatic chk_int(input string n, input int e, input int g);
        comparisons++;
        if (g != e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
        end
    endtask : chk_int
    function automatic logic [43:0] gain_vec();
        for (int i = 0; i < 4; i++) gain_vec[i*11 +: 11] = exp_gain[i];
    endfunction : gain_vec
    function automatic logic [43:0] ofs_vec();
        ofs_vec = 44'h00000000000;
        for (int i = 0; i < 4; i++) ofs_vec[i*7 +: 7] = exp_ofs[i];
    endfunction : ofs_vec
    // Three spellings of one gain: plain tenths, signed, with point
    function automatic string gstr(input int g, input int form);
        if (form == 0) return $sformatf("%0d", g);
        if (form == 1) return $sformatf("-%0d", g);
        return $sformatf("%0d.%0d", g / 10, g % 10);
    endfunction : gstr
    task automatic raw(input string s);
        for (int i = 0; i < s.len(); i++) host_link_model_inst.send_byte(s[i]);
    endtask : raw
    // Framed command, then the ack is given time to finish before checking
    task automatic run(input string body, input bit ok, input int ch, input bit ofs, input int val);
        raw({"{", pfx, body, "}"});
        repeat (100) @(negedge i_ref_clk);
        if (ok && ofs) exp_ofs[ch] = val[6:0];
        if (ok && !ofs) exp_gain[ch] = val[10:0];
        if (ok) exp_acks++;
        chk_vec("gain", gain_vec(), gain_bus);
        chk_vec("offset", ofs_vec(), {16'h0000, offset_bus});
        chk_int("acks", exp_acks, host_link_model_inst.ack_count);
        chk_int("bad frames", 0, host_link_model_inst.bad_count);
    endtask : run
    // Reset at a falling edge, then every setting must be back at its reset value
    task automatic reset_dut(input int n);
        i_reset_n = 1'b0;
        for (int i = 0; i < 4; i++) begin
            exp_gain[i] = atten_cmd_pkg::GAIN_RESET;
            exp_ofs[i] = atten_cmd_pkg::OFS_RESET;
        end
        repeat (n) @(negedge i_ref_clk);
        i_reset_n = 1'b1;
        chk_vec("reset gain", gain_vec(), gain_bus);
        chk_vec("reset offset", ofs_vec(), {16'h0000, offset_bus});
    endtask : reset_dut
    initial begin
        void'($urandom(32'h0B28AD69));
        reset_dut(8);
        for (int ch = 0; ch < 4; ch++) begin
            v = $urandom % 61;
            run($sformatf("C%c%02d", 8'h61 + ch, v), 1, ch, 1, v);
            v = exp_ofs[ch] * 10 + 100 + 5 * ($urandom % 121);
            run({$sformatf("C%c", 8'h41 + ch), gstr(v, ch % 3)}, 1, ch, 0, v);
        end
        run("Ca60", 1, 0, 1, 60);
        run("Ca61", 0, 0, 1, 0);
        run("CA69.5", 0, 0, 0, 0);
        run("CA-700", 1, 0, 0, 700);
        run("CA1300", 1, 0, 0, 1300);
        run("CA1305", 0, 0, 0, 0);
        run("CA4796", 0, 0, 0, 0);
        run("CA702", 0, 0, 0, 0);
        run("CE455", 0, 0, 0, 0);
        raw("Cc30}");
        raw("{Ca5");
        run("Cb20", 1, 1, 1, 20);
        i_multidrop = 1'b1;
        a = $urandom % 32;
        i_unit_address = a[4:0];
        pfx = $sformatf("%02d", a);
        run("Cd45", 1, 3, 1, 45);
        pfx = $sformatf("%02d", (a + 1) % 32);
        run("Cd10", 0, 3, 1, 0);
        pfx = "";
        run("Cd10", 0, 3, 1, 0);
        i_unit_address = 5'h1F;
        pfx = "31";
        run("CD1000", 1, 3, 0, 1000);
        reset_dut(3);
        run("Cc60", 1, 2, 1, 60);
        print_verdict();
    end
endmodule : tb_top
